// ---- design/txf_formatter.v ----
// Purpose: Transmit buffer with host write port, status flags and character formatter/packer.
// Assumes: host_write_clock and reference_clock are one-cycle enables synchronous to pclk.
// Notes:   Encoder output is an 8-bit character plus special flag, at most one per reference tick.
`timescale 1ns/1ps
`default_nettype none
`include "txf_defs.vh"

module txf_formatter #(
   parameter WIDTH = `TXF_WIDTH,
   parameter DEPTH = `TXF_DEPTH,
   parameter AW    = `TXF_AW
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        host_write_clock,
   input  wire        address_match_n,
   input  wire        tx_write_enable,
   input  wire [9:0]  tx_parallel_in,
   input  wire        special_char_select,
   input  wire        violation_force,
   input  wire        marker_bit,
   output reg         buffer_full_flag,
   output reg         buffer_half_flag,
   output reg         buffer_empty_flag,
   input  wire        reference_clock,
   output reg  [7:0]  enc_data,
   output reg         enc_special,
   output reg         enc_valid
);

   // ****************************************
   // Register file
   // ****************************************
   reg  [3:0]       ctrl;
   reg  [AW:0]      wr_ptr;
   reg  [AW:0]      rd_ptr;
   reg  [1:0]       state;
   reg  [2:0]       phase;
   wire [AW:0]      count = wr_ptr - rd_ptr;
   wire             buffer_bypass_n = ctrl[`TXF_CTRL_BUFEN];
   wire             encoder_en = ctrl[`TXF_CTRL_ENCEN];
   wire             pack_en = ctrl[`TXF_CTRL_PACK];
   wire             interface_convention_sel = ctrl[`TXF_CTRL_CONV];
   wire             full = (count == DEPTH[AW:0]);
   wire             empty = (count == {(AW+1){1'b0}});
   wire             half = (count >= `TXF_HALF);
   wire             apb_setup = psel & ~penable;
   wire             apb_write = psel & penable & pready & pwrite;
   wire             hit_ctrl = (paddr == `TXF_OFF_CTRL);
   wire             hit_status = (paddr == `TXF_OFF_STATUS);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= `TXF_CTRL_RESET;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         if (apb_setup) begin
            pslverr <= ~(hit_ctrl | hit_status);
            if (pwrite) begin
               prdata <= 32'h0000_0000;
            end else if (hit_ctrl) begin
               prdata <= {28'h000_0000, ctrl};
            end else if (hit_status) begin
               // Status word: phase, state, the three true-sense levels and the live count.
               prdata <= {9'h000, phase, 2'h0, state, 1'b0, full, half, empty, {(12-AW-1){1'b0}}, count};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end else begin
            // Read data and error response stand for the access cycle only.
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
         if (apb_write && hit_ctrl) begin
            ctrl <= pwdata[3:0];
         end
      end
   end

   // ****************************************
   // Host write side
   // ****************************************
   reg              selected;
   reg              wr_pend;
   wire             we_active = interface_convention_sel ? tx_write_enable : ~tx_write_enable;
   wire [WIDTH-1:0] in_word = {marker_bit, violation_force, special_char_select, 1'b0, tx_parallel_in};
   // Selection lasts while the enable stays active, so a burst needs the match only once.
   wire             sel_now = selected | ~address_match_n;
   wire             wr_req = interface_convention_sel ? wr_pend : (sel_now & we_active);
   wire             do_write = host_write_clock & buffer_bypass_n & wr_req & ~full;
   // Both conventions store the word present at the writing tick; cascade only delays the enable.
   wire [WIDTH-1:0] wr_word = in_word;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         selected <= 1'b0;
         wr_pend  <= 1'b0;
         wr_ptr   <= {(AW+1){1'b0}};
      end else if (host_write_clock) begin
         if (!we_active) begin
            selected <= ~address_match_n;
         end else if (!address_match_n) begin
            selected <= 1'b1;
         end
         wr_pend <= sel_now & we_active;
         if (do_write) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
      end
   end

   // Reset shows the flags idle in the default active-low convention.
   // flags on host tick
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buffer_full_flag  <= 1'b1;
         buffer_half_flag  <= 1'b1;
         buffer_empty_flag <= 1'b0;
      end else if (host_write_clock) begin
         buffer_full_flag  <= full ^ ~interface_convention_sel;
         buffer_half_flag  <= half ^ ~interface_convention_sel;
         buffer_empty_flag <= empty ^ ~interface_convention_sel;
      end
   end

   // ****************************************
   // Storage
   // ****************************************
   wire [WIDTH-1:0] head;
   reg              settled;

   txf_mem #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .pclk    (pclk),
      .wr_en   (do_write),
      .wr_addr (wr_ptr[AW-1:0]),
      .wr_data (wr_word),
      .rd_addr (rd_ptr[AW-1:0]),
      .rd_data (head)
   );

   // ****************************************
   // Read-side formatter and packer
   // ****************************************
   // The registered read port lags the pointers by one cycle, so a head entry is
   // trusted only once no pointer or write has moved in the previous cycle.
   // A limitation: after a pop a reference tick two cycles later loses its slot, and one a cycle later reuses the stale head.
   reg  [7:0]       carry;
   reg  [7:0]       hold;
   reg              pop;
   wire             avail = ~empty & settled & buffer_bypass_n;
   wire             fmt_on = buffer_bypass_n & encoder_en;
   wire             packing = pack_en & buffer_bypass_n;
   wire [2:0]       combo = {head[`TXF_F_MARK], head[`TXF_F_SPEC], head[`TXF_F_VIOL]};
   wire [9:0]       hd = head[`TXF_F_DATA_HI:0];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settled <= 1'b0;
      end else begin
         settled <= ~(pop | do_write);
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ptr      <= {(AW+1){1'b0}};
         state       <= `TXF_ST_IDLE;
         phase       <= 3'h0;
         carry       <= 8'h00;
         hold        <= 8'h00;
         pop         <= 1'b0;
         enc_data    <= 8'h00;
         enc_special <= 1'b0;
         enc_valid   <= 1'b0;
      end else begin
         pop       <= 1'b0;
         enc_valid <= 1'b0;
         if (reference_clock) begin
            case (state)
               `TXF_ST_DATA: begin
                  enc_data    <= hold;
                  enc_special <= 1'b0;
                  enc_valid   <= 1'b1;
                  state       <= `TXF_ST_IDLE;
               end
               `TXF_ST_FILL: begin
                  enc_data    <= `TXF_K_FILL;
                  enc_special <= 1'b1;
                  enc_valid   <= 1'b1;
                  phase       <= 3'h0;
                  state       <= `TXF_ST_IDLE;
               end
               `TXF_ST_IDLE: begin
                  if (packing) begin
                     if (phase == 3'h4) begin
                        enc_data    <= carry;
                        enc_special <= 1'b0;
                        enc_valid   <= 1'b1;
                        carry       <= 8'h00;
                        phase       <= 3'h0;
                     end else if (avail) begin
                        rd_ptr      <= rd_ptr + 1'b1;
                        pop         <= 1'b1;
                        enc_special <= 1'b0;
                        enc_valid   <= 1'b1;
                        phase       <= phase + 3'h1;
                        case (phase)
                           3'h0: begin
                              enc_data <= hd[7:0];
                              carry    <= {6'h00, hd[9:8]};
                           end
                           3'h1: begin
                              enc_data <= {hd[5:0], carry[1:0]};
                              carry    <= {4'h0, hd[9:6]};
                           end
                           3'h2: begin
                              enc_data <= {hd[3:0], carry[3:0]};
                              carry    <= {2'h0, hd[9:4]};
                           end
                           default: begin
                              enc_data <= {hd[1:0], carry[5:0]};
                              carry    <= hd[9:2];
                           end
                        endcase
                     end else if (empty && phase != 3'h0) begin
                        // Only a dry buffer pads; a head still settling after a write waits a tick.
                        // pad partial group
                        enc_data    <= carry;
                        enc_special <= 1'b0;
                        enc_valid   <= 1'b1;
                        carry       <= 8'h00;
                        state       <= `TXF_ST_FILL;
                     end
                  end else if (avail) begin
                     rd_ptr    <= rd_ptr + 1'b1;
                     pop       <= 1'b1;
                     enc_valid <= 1'b1;
                     hold      <= hd[7:0];
                     if (!fmt_on) begin
                        enc_data    <= hd[7:0];
                        enc_special <= head[`TXF_F_SPEC];
                     end else begin
                        case (combo)
                           3'b000, 3'b010: begin
                              enc_data    <= hd[7:0];
                              enc_special <= head[`TXF_F_SPEC];
                           end
                           3'b100: begin
                              enc_data    <= `TXF_K_SOC;
                              enc_special <= 1'b1;
                              state       <= `TXF_ST_DATA;
                           end
                           3'b110: begin
                              enc_data    <= `TXF_K_EXT;
                              enc_special <= 1'b1;
                              state       <= `TXF_ST_DATA;
                           end
                           3'b111: begin
                              enc_data    <= `TXF_K_ADDR;
                              enc_special <= 1'b1;
                              state       <= `TXF_ST_DATA;
                           end
                           default: begin
                              enc_data    <= `TXF_K_VIOL;
                              enc_special <= 1'b1;
                           end
                        endcase
                     end
                  end
               end
               default: begin
                  state <= `TXF_ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ---- design/txf_defs.vh ----
// Purpose: Constants shared by the transmit buffer and formatter design files.
// Assumes: Included by bare name from the formatter design file and the bench; the storage file does not include it.
// Notes:   Definitions only.
`ifndef TXF_DEFS_VH
`define TXF_DEFS_VH

// ****************************************
// Buffer geometry
// ****************************************
`define TXF_DEPTH        256
`define TXF_AW           8
`define TXF_WIDTH        14
`define TXF_HALF         9'h080

// ****************************************
// Buffer entry layout
// ****************************************
`define TXF_F_MARK       13
`define TXF_F_VIOL       12
`define TXF_F_SPEC       11
`define TXF_F_RSVD       10
`define TXF_F_DATA_HI    9

// ****************************************
// Register map and fields
// ****************************************
`define TXF_OFF_CTRL     12'h000
`define TXF_OFF_STATUS   12'h004
`define TXF_CTRL_BUFEN   0
`define TXF_CTRL_ENCEN   1
`define TXF_CTRL_PACK    2
`define TXF_CTRL_CONV    3
`define TXF_CTRL_RESET   4'h0

// ****************************************
// Special character codes, y in [7:5], x in [4:0]
// ****************************************
`define TXF_K_VIOL       8'he0
`define TXF_K_FILL       8'h05
`define TXF_K_SOC        8'h08
`define TXF_K_EXT        8'h09
`define TXF_K_ADDR       8'h0a

// ****************************************
// Read-side states
// ****************************************
`define TXF_ST_IDLE      2'h0
`define TXF_ST_DATA      2'h1
`define TXF_ST_FILL      2'h2

`endif

// ---- design/txf_mem.v ----
// Purpose: Simple dual-port storage for the transmit buffer.
// Assumes: One clock; read data registered.
// Notes:   Storage has no reset; validity is tracked by the pointers.
`timescale 1ns/1ps
`default_nettype none

module txf_mem #(
   parameter WIDTH = 14,
   parameter DEPTH = 256,
   parameter AW    = 8
) (
   input  wire             pclk,
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data,
   input  wire [AW-1:0]    rd_addr,
   output reg  [WIDTH-1:0] rd_data
);

   reg [WIDTH-1:0] store [0:DEPTH-1];

   always @(posedge pclk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
      rd_data <= store[rd_addr];
   end

endmodule

`default_nettype wire

// ---- sim/txf_checker.sv ----
// Purpose: Port checks for the transmit buffer, formatter and APB slave.
// Assumes: One pclk domain; presetn low clears all state except the storage array and its registered read data.
// Notes:   Attached by bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module txf_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        host_write_clock,
   input wire logic        reference_clock,
   input wire logic        buffer_full_flag,
   input wire logic        buffer_half_flag,
   input wire logic        buffer_empty_flag,
   input wire logic [7:0]  enc_data,
   input wire logic        enc_valid
);
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_access: assert property (psel && !penable |=> pready)
      else $error("ready missing in access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   a_ready_idle: assert property (!psel |-> !pready)
      else $error("ready without select");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error response outside access cycle");
   a_err_unmapped: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
      else $error("error response does not match address map");
   a_ctrl_upper: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[31:4] == 28'h0)
      else $error("unused control bits read nonzero");
   a_valid_cause: assert property (enc_valid |-> $past(reference_clock))
      else $error("character without reference tick");
   a_valid_pulse: assert property (enc_valid |=> !enc_valid)
      else $error("valid held past one cycle");
   a_data_hold: assert property (!enc_valid |-> $stable(enc_data))
      else $error("encoder data moved without valid");
   // Flags may only move at a host tick, so the write side never follows the reference tick.
   a_flag_hold: assert property (!$past(host_write_clock) |->
      $stable({buffer_full_flag, buffer_half_flag, buffer_empty_flag}))
      else $error("flags changed without host tick");
endmodule

bind txf_formatter txf_checker i_chk (
   .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .host_write_clock,
   .reference_clock, .buffer_full_flag, .buffer_half_flag, .buffer_empty_flag, .enc_data, .enc_valid);
`default_nettype wire

// ---- sim/txf_host_model.sv ----
// Purpose: Host-side writer feeding the transmit input register.
// Assumes: conv follows the convention select written into CTRL.
// Notes:   Released data lines carry the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none

module txf_host_model (
   input  wire logic       pclk,
   input  wire logic       conv,
   output var  logic       host_write_clock,
   output var  logic       address_match_n,
   output var  logic       tx_write_enable,
   output var  logic [9:0] tx_parallel_in,
   output var  logic       special_char_select,
   output var  logic       violation_force,
   output var  logic       marker_bit
);
   // ****************************************
   // Host ticks
   // ****************************************
   initial begin
      host_write_clock = 1'b0;
      address_match_n  = 1'b1;
      tx_write_enable  = 1'b1;
      {marker_bit, special_char_select, violation_force, tx_parallel_in} = 13'h0000;
   end

   task automatic tick(input logic am_n, input logic act, input logic [12:0] v);
      address_match_n  <= am_n;
      tx_write_enable  <= act ^ ~conv;
      {marker_bit, special_char_select, violation_force, tx_parallel_in} <= v;
      host_write_clock <= 1'b1;
      @(posedge pclk);
      host_write_clock <= 1'b0;
      address_match_n  <= 1'b1;
      tx_write_enable  <= ~conv;
      {marker_bit, special_char_select, violation_force, tx_parallel_in} <= ~v;
      @(posedge pclk);
   endtask

   // with conv set, enable leads data by one tick; otherwise both share one tick
   task automatic put(input logic [12:0] v);
      if (conv) begin
         tick(1'b0, 1'b1, ~v);
         tick(1'b1, 1'b0, v);
      end else begin
         tick(1'b0, 1'b1, v);
      end
   endtask

   task automatic idle;
      tick(1'b1, 1'b0, 13'h0000);
   endtask
endmodule
`default_nettype wire

// ---- sim/test_tx_fifo_formatter_packer.sv ----
// Purpose: Self-checking bench for the transmit buffer, formatter and packer.
// Assumes: Host and reference ticks are one-cycle enables on pclk.
// Notes:   Host writes come from the partner model; registers go over APB.
`timescale 1ns/1ps
`default_nettype none
`include "txf_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end

module test_tx_fifo_formatter_packer;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, conv, reference_clock, rerr;
   logic        host_write_clock, address_match_n, tx_write_enable, special_char_select, violation_force;
   logic        marker_bit, buffer_full_flag, buffer_half_flag, buffer_empty_flag, enc_special, enc_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [9:0]  tx_parallel_in;
   logic [7:0]  enc_data;
   logic [8:0]  got_q[$];
   logic [9:0]  pk[5];
   int          failures, check_count, i;
   wire logic [2:0] flags = {buffer_full_flag, buffer_half_flag, buffer_empty_flag};

   txf_formatter i_dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .host_write_clock, .address_match_n, .tx_write_enable, .tx_parallel_in, .special_char_select,
      .violation_force, .marker_bit, .buffer_full_flag, .buffer_half_flag, .buffer_empty_flag,
      .reference_clock, .enc_data, .enc_special, .enc_valid);
   txf_host_model i_host (
      .pclk, .conv, .host_write_clock, .address_match_n, .tx_write_enable, .tx_parallel_in,
      .special_char_select, .violation_force, .marker_bit);

   // ****************************************
   // Bus and stream tasks
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk) if (enc_valid === 1'b1) got_q.push_back({enc_special, enc_data});

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) begin
         failures++;
         results();
      end else begin
         rdata = prdata;
         rerr  = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   // Three cycles between ticks keeps pops apart, as the read side needs three.
   task automatic run_ref(input int k);
      repeat (k) begin
         reference_clock <= 1'b1;
         @(posedge pclk);
         reference_clock <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask

   task automatic check_q(input logic [8:0] e);
      logic [8:0] g;
      g = 'x;
      if (got_q.size() != 0) g = got_q.pop_front();
      `CHK("encoder output", e, g)
   endtask

   task automatic results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      results();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {presetn, psel, penable, pwrite, conv, reference_clock} = 6'h00;
      paddr  = 12'h000;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `TXF_OFF_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0, rdata)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {rerr, rdata})
      i_host.put(13'h0123);
      i_host.idle();
      `CHK("flags idle", 3'b110, flags)
      apb(1'b0, `TXF_OFF_STATUS, 32'h0);
      `CHK("count buffer off", 9'h000, rdata[8:0])
      $display("test registers done");
      apb(1'b1, `TXF_OFF_CTRL, 32'h3);
      apb(1'b0, `TXF_OFF_CTRL, 32'h0);
      `CHK("ctrl readback", 32'h3, rdata)
      for (i = 0; i < 8; i++) i_host.put({i[2:0], 10'h340 + 10'(i)});
      apb(1'b0, `TXF_OFF_STATUS, 32'h0);
      `CHK("count format", 9'h008, rdata[8:0])
      run_ref(12);
      for (i = 0; i < 8; i++) begin
         if (i == 1 || i == 3 || i == 5) check_q({1'b1, `TXF_K_VIOL});
         else if (i >= 4) begin
            check_q({1'b1, (i == 4) ? `TXF_K_SOC : (i == 6) ? `TXF_K_EXT : `TXF_K_ADDR});
            check_q({1'b0, 8'h40 + 8'(i)});
         end
         else check_q({i[1], 8'h40 + 8'(i)});
      end
      `CHK("format idle", 0, got_q.size())
      i_host.idle();
      `CHK("flags drained", 3'b110, flags)
      $display("test formatting done");
      apb(1'b1, `TXF_OFF_CTRL, 32'h5);
      pk = '{10'h2a5, 10'h13c, 10'h3f0, 10'h0e7, 10'h28d};
      for (i = 0; i < 5; i++) i_host.put({3'b100, pk[i]});
      run_ref(9);
      check_q({1'b0, pk[0][7:0]});
      check_q({1'b0, pk[1][5:0], pk[0][9:8]});
      check_q({1'b0, pk[2][3:0], pk[1][9:6]});
      check_q({1'b0, pk[3][1:0], pk[2][9:4]});
      check_q({1'b0, pk[3][9:2]});
      check_q({1'b0, pk[4][7:0]});
      check_q({3'b000, 4'h0, pk[4][9:8]});
      check_q({1'b1, `TXF_K_FILL});
      i_host.put({3'b000, pk[1]});
      run_ref(4);
      check_q({1'b0, pk[1][7:0]});
      check_q({3'b000, 4'h0, pk[1][9:8]});
      check_q({1'b1, `TXF_K_FILL});
      `CHK("pack idle", 0, got_q.size())
      $display("test packing done");
      apb(1'b1, `TXF_OFF_CTRL, 32'h1);
      for (i = 0; i < 257; i++) i_host.put({3'b000, 10'(i)});
      i_host.idle();
      apb(1'b0, `TXF_OFF_STATUS, 32'h0);
      `CHK("count full", 9'h100, rdata[8:0])
      `CHK("flags full", 3'b001, flags)
      run_ref(257);
      for (i = 0; i < 256; i++) check_q({1'b0, 8'(i)});
      `CHK("drained", 0, got_q.size())
      i_host.idle();
      `CHK("flags empty", 3'b110, flags)
      $display("test full buffer done");
      conv <= 1'b1;
      apb(1'b1, `TXF_OFF_CTRL, 32'hb);
      i_host.put({3'b000, 10'h05a});
      apb(1'b0, `TXF_OFF_STATUS, 32'h0);
      `CHK("count cascade", 9'h001, rdata[8:0])
      i_host.idle();
      `CHK("flags cascade", 3'b000, flags)
      run_ref(2);
      check_q({1'b0, 8'h5a});
      i_host.idle();
      `CHK("cascade empty", 3'b001, flags)
      $display("test cascade done");
      results();
   end
endmodule
`default_nettype wire
